// ===== include/pid_pkg.sv
// ****************************************************************
// constants and types of the feedback controller core
// ****************************************************************
package pid_pkg;
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int FRAC = 8;
	localparam int ACCW = 40;
	localparam int NSETS = 8;
	localparam int SETW = 3;
	localparam int PCTW = 7;
	// per-set field index, address bits [3:0] with bit 7 clear
	localparam logic [3:0] F_MODE = 4'h0;
	localparam logic [3:0] F_DZONE = 4'h1;
	localparam logic [3:0] F_KP = 4'h2;
	localparam logic [3:0] F_KI = 4'h3;
	localparam logic [3:0] F_KD = 4'h4;
	localparam logic [3:0] F_DIFF = 4'h5;
	localparam logic [3:0] F_OFFSET = 4'h6;
	localparam logic [3:0] F_LOLIM = 4'h7;
	localparam logic [3:0] F_HILIM = 4'h8;
	localparam logic [3:0] F_INITTYPE = 4'h9;
	localparam logic [3:0] F_INITPCT = 4'hA;
	localparam int SET_LSB = 4;
	localparam int GLOBAL_BIT = 7;
	// global registers
	localparam logic [AW-1:0] A_CTRL = 8'h80;
	localparam logic [AW-1:0] A_STATUS = 8'h81;
	localparam logic [AW-1:0] A_OUT = 8'h82;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_SEL_LSB = 4;
	localparam int STAT_RUN = 0;
	localparam int STAT_DZ = 1;
	// mode encodings
	localparam logic [1:0] MODE_PD = 2'h0;
	localparam logic [1:0] MODE_PI = 2'h1;
	localparam logic [1:0] MODE_PID = 2'h2;
	localparam logic [PCTW-1:0] PCT_FULL = 7'h64;
	// reset values of every setting set
	localparam logic [1:0] RST_MODE = MODE_PID;
	localparam logic [DW-1:0] RST_ZERO = 16'h0000;
	localparam logic [DW-1:0] RST_HILIM = 16'h7FFF;
	typedef struct packed {
		logic [1:0] mode;
		logic [DW-1:0] dead_zone;
		logic [DW-1:0] kp;
		logic [DW-1:0] ki;
		logic [DW-1:0] kd;
		logic diff_fb;
		logic [DW-1:0] offset;
		logic [DW-1:0] lo_lim;
		logic [DW-1:0] hi_lim;
		logic init_val;
		logic [PCTW-1:0] init_pct;
	} cfg_s;
	typedef enum logic {ST_IDLE, ST_RUN} run_state_e;
endpackage

// ===== include/pid_cfg_if.sv
`timescale 1ns/10ps
// ****************************************************************
// link between controller datapath and setting bank
// ****************************************************************
interface pid_cfg_if;
	import pid_pkg::*;
	logic wr_en;
	logic [SETW-1:0] wr_set;
	logic [3:0] wr_field;
	logic [DW-1:0] wr_data;
	logic [SETW-1:0] rd_set;
	logic [3:0] rd_field;
	logic [DW-1:0] rd_data;
	logic [SETW-1:0] act_set;
	cfg_s act_cfg;
	modport bank (input wr_en, wr_set, wr_field, wr_data, rd_set, rd_field, act_set, output rd_data, act_cfg);
	modport core (output wr_en, wr_set, wr_field, wr_data, rd_set, rd_field, act_set, input rd_data, act_cfg);
endinterface

// ===== verilog/pid_set_bank.sv
`timescale 1ns/10ps
// ****************************************************************
// storage of the eight controller setting sets
// ****************************************************************
module pid_set_bank
	import pid_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	pid_cfg_if.bank cfg_bus
);
	cfg_s set_reg [NSETS];
	cfg_s rd_cfg;

	// field writes into the addressed set, all sets reset alike
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NSETS; i++)
			begin
				set_reg[i] <= '0;
				set_reg[i].mode <= RST_MODE;
				set_reg[i].hi_lim <= RST_HILIM;
				set_reg[i].lo_lim <= RST_ZERO;
			end
		end
		else if (cfg_bus.wr_en)
		begin
			case (cfg_bus.wr_field)
				F_MODE: set_reg[cfg_bus.wr_set].mode <= cfg_bus.wr_data[1:0];
				F_DZONE: set_reg[cfg_bus.wr_set].dead_zone <= cfg_bus.wr_data;
				F_KP: set_reg[cfg_bus.wr_set].kp <= cfg_bus.wr_data;
				F_KI: set_reg[cfg_bus.wr_set].ki <= cfg_bus.wr_data;
				F_KD: set_reg[cfg_bus.wr_set].kd <= cfg_bus.wr_data;
				F_DIFF: set_reg[cfg_bus.wr_set].diff_fb <= cfg_bus.wr_data[0];
				F_OFFSET: set_reg[cfg_bus.wr_set].offset <= cfg_bus.wr_data;
				F_LOLIM: set_reg[cfg_bus.wr_set].lo_lim <= cfg_bus.wr_data;
				F_HILIM: set_reg[cfg_bus.wr_set].hi_lim <= cfg_bus.wr_data;
				F_INITTYPE: set_reg[cfg_bus.wr_set].init_val <= cfg_bus.wr_data[0];
				F_INITPCT: set_reg[cfg_bus.wr_set].init_pct <= cfg_bus.wr_data[PCTW-1:0];
				default: ;
			endcase
		end
	end

	// read mux, unused field indices read zero
	always_comb
	begin
		rd_cfg = set_reg[cfg_bus.rd_set];
		case (cfg_bus.rd_field)
			F_MODE: cfg_bus.rd_data = {14'h0000, rd_cfg.mode};
			F_DZONE: cfg_bus.rd_data = rd_cfg.dead_zone;
			F_KP: cfg_bus.rd_data = rd_cfg.kp;
			F_KI: cfg_bus.rd_data = rd_cfg.ki;
			F_KD: cfg_bus.rd_data = rd_cfg.kd;
			F_DIFF: cfg_bus.rd_data = {15'h0000, rd_cfg.diff_fb};
			F_OFFSET: cfg_bus.rd_data = rd_cfg.offset;
			F_LOLIM: cfg_bus.rd_data = rd_cfg.lo_lim;
			F_HILIM: cfg_bus.rd_data = rd_cfg.hi_lim;
			F_INITTYPE: cfg_bus.rd_data = {15'h0000, rd_cfg.init_val};
			F_INITPCT: cfg_bus.rd_data = {9'h000, rd_cfg.init_pct};
			default: cfg_bus.rd_data = 16'h0000;
		endcase
	end

	// the set chosen by the channel feeds the datapath
	assign cfg_bus.act_cfg = set_reg[cfg_bus.act_set];
endmodule

// ===== verilog/pid_controller_core.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
// ****************************************************************
// three-term feedback controller with dead zone and clamping
// ****************************************************************
// Summary of operation
// - eight setting sets, any one selectable
// - mode chooses PD, PI or PID
// - error is setpoint minus feedback
// - inside dead zone the output holds
// - proportional term always applied
// - integral only in PI and PID
// - derivative only in PD and PID
// - feedback derivative skips dead zone
// - error derivative follows dead zone check
// - offset added to computed output
// - result clamped between low and high limits
// - no-init start: output and state zero
// - value start: percentage between the limits
module pid_controller_core
	import pid_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	input wire logic [DW-1:0] setpoint,
	input wire logic [DW-1:0] feedback,
	input wire logic sample_valid,
	output logic [DW-1:0] ctrl_out,
	output logic out_valid,
	output logic running
);
	pid_cfg_if cfg_bus ();
	cfg_s cfg;
	run_state_e state_reg;
	logic [SETW-1:0] sel_reg;
	logic [DW-1:0] out_reg;
	logic signed [ACCW-1:0] i_acc_reg;
	logic signed [DW:0] err_prev_reg;
	logic [DW-1:0] fb_prev_reg;
	logic dz_reg;
	logic valid_reg;
	logic [DW-1:0] rdata_reg;
	logic start;
	logic live;
	logic use_i;
	logic use_d;
	logic signed [DW:0] err;
	logic [DW:0] abs_err;
	logic beyond;
	logic signed [DW+1:0] d_src;
	logic signed [ACCW-1:0] err_x, kp_x, ki_x, kd_x, off_x, lo_x, hi_x, dsrc_x;
	logic signed [ACCW-1:0] p_term, i_next, d_term, pid_sum, pid_val, with_off, clamped;
	logic signed [ACCW-1:0] span, pct_x, init_out, init_i;
	logic [PCTW-1:0] pct_lim;

	// ****************************************************************
	// setting bank
	// ****************************************************************
	pid_set_bank u_bank (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cfg_bus(cfg_bus)
	);

	// bus decode towards the bank; bit 7 clear selects a set field
	assign cfg_bus.wr_en = wr && !addr[GLOBAL_BIT];
	assign cfg_bus.wr_set = addr[SET_LSB +: SETW];
	assign cfg_bus.wr_field = addr[3:0];
	assign cfg_bus.wr_data = wdata;
	assign cfg_bus.rd_set = addr[SET_LSB +: SETW];
	assign cfg_bus.rd_field = addr[3:0];
	// a start reads the set that its own write selects, not the old one
	assign cfg_bus.act_set = start ? wdata[CTRL_SEL_LSB +: SETW] : sel_reg;
	assign cfg = cfg_bus.act_cfg;

	// ****************************************************************
	// run control
	// ****************************************************************
	// start is a run request seen while idle
	assign start = wr && (addr == A_CTRL) && wdata[CTRL_RUN] && (state_reg == ST_IDLE);
	assign live = (state_reg == ST_RUN) && sample_valid;

	// run state follows the run bit of the control register
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			state_reg <= ST_IDLE;
		else if (wr && addr == A_CTRL)
		begin
			case (state_reg)
				ST_IDLE: state_reg <= wdata[CTRL_RUN] ? ST_RUN : ST_IDLE;
				ST_RUN: state_reg <= wdata[CTRL_RUN] ? ST_RUN : ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// setting set selected by this channel
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			sel_reg <= '0;
		else if (wr && addr == A_CTRL)
			sel_reg <= wdata[CTRL_SEL_LSB +: SETW];
	end

	// ****************************************************************
	// datapath
	// ****************************************************************
	// term enables from the mode; unused code 3 behaves as full PID
	assign use_i = (cfg.mode != MODE_PD);
	assign use_d = (cfg.mode != MODE_PI);

	// error and dead zone test
	assign err = $signed({setpoint[DW-1], setpoint}) - $signed({feedback[DW-1], feedback});
	assign abs_err = err[DW] ? (DW+1)'(0) - err : err;
	assign beyond = abs_err > {1'b0, cfg.dead_zone};

	// differentiated signal: falling feedback or change of error
	assign d_src = cfg.diff_fb
		? $signed({{2{fb_prev_reg[DW-1]}}, fb_prev_reg}) - $signed({{2{feedback[DW-1]}}, feedback})
		: $signed({err[DW], err}) - $signed({err_prev_reg[DW], err_prev_reg});

	// widen operands to accumulator width, sign kept
	assign err_x = ACCW'(err);
	assign dsrc_x = ACCW'(d_src);
	assign kp_x = ACCW'($signed(cfg.kp));
	assign ki_x = ACCW'($signed(cfg.ki));
	assign kd_x = ACCW'($signed(cfg.kd));
	assign off_x = ACCW'($signed(cfg.offset));
	assign lo_x = ACCW'($signed(cfg.lo_lim));
	assign hi_x = ACCW'($signed(cfg.hi_lim));

	// gains are signed with FRAC fraction bits
	assign p_term = kp_x * err_x;
	assign i_next = use_i ? i_acc_reg + ki_x * err_x : '0;
	assign d_term = use_d ? kd_x * dsrc_x : '0;
	assign pid_sum = p_term + i_next + d_term;
	assign pid_val = pid_sum >>> FRAC;
	assign with_off = pid_val + off_x;

	// clamp after offset
	always_comb
	begin
		if (with_off > hi_x)
			clamped = hi_x;
		else if (with_off < lo_x)
			clamped = lo_x;
		else
			clamped = with_off;
	end

	// starting output: zero, or linear share of the limit range
	assign pct_lim = (cfg.init_pct > PCT_FULL) ? PCT_FULL : cfg.init_pct;
	assign pct_x = ACCW'($signed({1'b0, pct_lim}));
	assign span = hi_x - lo_x;
	assign init_out = cfg.init_val ? lo_x + (span * pct_x) / ACCW'($signed({1'b0, PCT_FULL})) : '0;
	// integrator preloaded so the first sample continues from the start value
	assign init_i = (cfg.init_val && use_i) ? (init_out - off_x) <<< FRAC : '0;

	// ****************************************************************
	// controller state
	// ****************************************************************
	// output and integrator: start values, update outside dead zone
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			out_reg <= '0;
			i_acc_reg <= '0;
		end
		else if (start)
		begin
			out_reg <= init_out[DW-1:0];
			i_acc_reg <= init_i;
		end
		else if (live && beyond)
		begin
			out_reg <= clamped[DW-1:0];
			i_acc_reg <= i_next;
		end
	end

	// derivative history: feedback always, error only when noticed
	always_ff @(posedge clk_sys)
	begin
		if (!nrst || start)
		begin
			fb_prev_reg <= '0;
			err_prev_reg <= '0;
		end
		else if (live)
		begin
			fb_prev_reg <= feedback;
			if (beyond)
				err_prev_reg <= err;
		end
	end

	// result strobe and dead zone flag
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			valid_reg <= 1'b0;
			dz_reg <= 1'b0;
		end
		else
		begin
			valid_reg <= live;
			if (start)
				dz_reg <= 1'b0;
			else if (live)
				dz_reg <= !beyond;
		end
	end

	// ****************************************************************
	// register read port
	// ****************************************************************
	// data stand one cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_sys)
	begin
		if (!nrst || !rd)
			rdata_reg <= '0;
		else if (!addr[GLOBAL_BIT])
			rdata_reg <= cfg_bus.rd_data;
		else
		begin
			case (addr)
				A_CTRL: rdata_reg <= {9'h000, sel_reg, 3'h0, state_reg == ST_RUN};
				A_STATUS: rdata_reg <= {14'h0000, dz_reg, state_reg == ST_RUN};
				A_OUT: rdata_reg <= out_reg;
				default: rdata_reg <= '0;
			endcase
		end
	end

	assign rdata = rdata_reg;
	assign ctrl_out = out_reg;
	assign out_valid = valid_reg;
	assign running = (state_reg == ST_RUN);

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_noticed;
		live && beyond;
	endsequence

	sequence s_ignored;
		live && !beyond;
	endsequence

	sequence s_start_plain;
		start && !cfg.init_val;
	endsequence

	a_dead_zone_hold: assert property (s_ignored |=> $stable(ctrl_out) && $stable(i_acc_reg))
		else $error("output moved inside dead zone");
	a_clamp_high: assert property (s_noticed ##0 (with_off > hi_x) |=> ctrl_out == $past(cfg.hi_lim))
		else $error("output not clamped to high limit");
	a_clamp_low: assert property (s_noticed ##0 (with_off < lo_x) |=> ctrl_out == $past(cfg.lo_lim))
		else $error("output not clamped to low limit");
	a_offset_sum: assert property (s_noticed ##0 (with_off <= hi_x && with_off >= lo_x)
		|=> $signed(ctrl_out) == $past(pid_sum >>> FRAC) + $past(off_x))
		else $error("output is not terms plus offset");
	a_noinit_zero: assert property (s_start_plain |=> ctrl_out == '0 && i_acc_reg == '0)
		else $error("no-init start not zero");
	a_init_limits: assert property (start && cfg.init_val && pct_lim == PCT_FULL |=> ctrl_out == $past(cfg.hi_lim))
		else $error("full percentage start not at high limit");
	a_init_low: assert property (start && cfg.init_val && cfg.init_pct == '0 |=> ctrl_out == $past(cfg.lo_lim))
		else $error("zero percentage start not at low limit");
	a_pd_no_integral: assert property (s_noticed ##0 (cfg.mode == MODE_PD) |=> i_acc_reg == '0)
		else $error("integrator used in PD mode");
	a_pi_no_deriv: assert property (use_i && !use_d |-> d_term == '0 && pid_sum == p_term + i_next)
		else $error("derivative used in PI mode");
	a_fb_history: assert property (s_ignored ##0 cfg.diff_fb |=> fb_prev_reg == $past(feedback))
		else $error("feedback history skipped in dead zone");
	a_err_history: assert property (s_ignored |=> $stable(err_prev_reg))
		else $error("error history moved in dead zone");
	a_read_window: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data outside read window");

	// set selection, dead zone flag, result strobe and hold while stopped
	a_start_set: assert property (start |-> cfg_bus.act_set == wdata[CTRL_SEL_LSB +: SETW])
		else $error("start used a stale setting set");
	a_dz_flag: assert property (s_ignored |=> dz_reg)
		else $error("dead zone flag not raised");
	a_valid_strobe: assert property (live |=> out_valid)
		else $error("taken sample gave no result strobe");
	a_valid_quiet: assert property (!live |=> !out_valid)
		else $error("result strobe without a taken sample");
	a_idle_hold: assert property (!running && !start |=> $stable(ctrl_out))
		else $error("stopped controller moved its output");
endmodule

// ===== dv/chan_model.sv
`timescale 1ns/10ps
// ****************************************************************
// channel source and actuator sink model
// ****************************************************************
module chan_model
	import pid_pkg::*;
(
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [DW-1:0] sp_in,
	input wire logic [DW-1:0] fb_in,
	input wire logic out_valid,
	output logic [DW-1:0] setpoint,
	output logic [DW-1:0] feedback,
	output logic sample_valid,
	output int outs_seen
);
	// quiet start of both channels
	initial
	begin
		setpoint = 16'h0;
		feedback = 16'h0;
		sample_valid = 1'b0;
		outs_seen = 0;
	end
	// channel pair sent together; idle lines toggle so stale data never looks valid
	always @(posedge clk_sys)
	begin
		sample_valid <= go;
		setpoint <= go ? sp_in : ~setpoint;
		feedback <= go ? fb_in : ~feedback;
	end
	// actuator side counts delivered outputs
	always @(posedge clk_sys)
		if (out_valid === 1'b1)
			outs_seen <= outs_seen + 1;
endmodule

// ===== dv/tb_pid_controller_core.sv
`timescale 1ns/10ps
// ****************************************************************
// self-checking bench of the controller core
// ****************************************************************
module tb_pid_controller_core;
	import pid_pkg::*;
	typedef struct packed {logic [DW-1:0] md, dz, kp, ki, kd, df, of, lo, hi, sp, fb, ex;} row_s;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [AW-1:0] addr = 8'h00;
	logic [DW-1:0] wdata = 16'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic [DW-1:0] sp_in = 16'h0;
	logic [DW-1:0] fb_in = 16'h0;
	logic [DW-1:0] rdata, ctrl_out, setpoint, feedback, rv;
	logic out_valid, running, sample_valid;
	int outs_seen;
	int mismatches = 0;
	int checks_done = 0;
	int pcts [4] = '{0, 50, 100, 120};
	row_s r;
	// mode, dead zone, gains, diff select, offset, limits, sp, fb, expected output
	row_s rows [8] = '{
		'{16'h0, 16'h0, 16'h100, 16'h100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'h44},
		'{16'h1, 16'h0, 16'h100, 16'h100, 16'h100, 16'h0, 16'h0, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'h88},
		'{16'h3, 16'h0, 16'h100, 16'h0, 16'h200, 16'h0, 16'h0, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'hCC},
		'{16'h2, 16'h0, 16'h100, 16'h0, 16'h100, 16'h1, 16'h0, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'h24},
		'{16'h0, 16'h0, 16'h200, 16'h0, 16'h0, 16'h0, 16'h10, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'h98},
		'{16'h0, 16'h0, 16'h100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h40, 16'h64, 16'h20, 16'h40},
		'{16'h0, 16'h0, 16'h100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h30, 16'h7FFF, 16'h20, 16'h64, 16'h30},
		'{16'h2, 16'h44, 16'h100, 16'h100, 16'h100, 16'h1, 16'h0, 16'h0, 16'h7FFF, 16'h64, 16'h20, 16'h0}
	};

	// device and its channel partner
	pid_controller_core uut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .setpoint(setpoint), .feedback(feedback), .sample_valid(sample_valid),
		.ctrl_out(ctrl_out), .out_valid(out_valid), .running(running));
	chan_model pm (.clk_sys(clk_sys), .go(go), .sp_in(sp_in), .fb_in(fb_in), .out_valid(out_valid),
		.setpoint(setpoint), .feedback(feedback), .sample_valid(sample_valid), .outs_seen(outs_seen));

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	task tally_and_finish();
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task rreg(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// stop, load one set, then start on it
	task cfg(input logic [SETW-1:0] s, input row_s x, input logic [DW-1:0] it, input logic [DW-1:0] pct);
		logic [DW-1:0] v [11];
		v = '{x.md, x.dz, x.kp, x.ki, x.kd, x.df, x.of, x.lo, x.hi, it, pct};
		wreg(A_CTRL, 16'h0);
		for (int f = 0; f < 11; f++)
			wreg({1'b0, s, 4'(f)}, v[f]);
		wreg(A_CTRL, {9'h000, s, 3'h0, 1'b1});
		@(posedge clk_sys);
		#1;
	endtask

	// one sample pair, answer looked at just after the edge that takes it
	task samp(input logic [DW-1:0] sp, input logic [DW-1:0] fb);
		@(posedge clk_sys);
		go <= 1'b1;
		sp_in <= sp;
		fb_in <= fb;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	// watchdog far beyond the expected run
	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		#1 chk(ctrl_out, 16'h0);
		chk(16'(running), 16'h0);
		rreg({1'b0, 3'h3, F_MODE}, rv);
		chk(rv, {14'h0, RST_MODE});
		rreg({1'b0, 3'h3, F_HILIM}, rv);
		chk(rv, RST_HILIM);
		rreg(8'hFF, rv);
		chk(rv, 16'h0);
		@(posedge clk_sys);
		#1 chk(rdata, 16'h0);
		samp(16'h64, 16'h20);
		chk(16'(out_valid), 16'h0);
		// ordinary cases, one setting set each
		for (int i = 0; i < 8; i++)
		begin
			cfg(3'(i), rows[i], 16'h0, 16'h0);
			chk(ctrl_out, 16'h0);
			chk(16'(running), 16'h1);
			samp(rows[i].sp, rows[i].fb);
			chk(16'(out_valid), 16'h1);
			chk(ctrl_out, rows[i].ex);
			rreg(A_OUT, rv);
			chk(rv, rows[i].ex);
			rreg(A_STATUS, rv);
			chk(rv, {14'h0, i == 7, 1'b1});
		end
		// back-to-back samples grow the integral term
		cfg(3'h5, rows[1], 16'h0, 16'h0);
		@(posedge clk_sys);
		go <= 1'b1;
		sp_in <= 16'h64;
		fb_in <= 16'h20;
		repeat (2) @(posedge clk_sys);
		go <= 1'b0;
		#1 chk(ctrl_out, 16'h88);
		@(posedge clk_sys);
		#1 chk(ctrl_out, 16'hCC);
		@(posedge clk_sys);
		#1 chk(16'(out_valid), 16'h0);
		// run request while running only moves the set select
		rreg(A_CTRL, rv);
		chk(rv, 16'h0051);
		wreg(A_CTRL, 16'h0061);
		rreg(A_CTRL, rv);
		chk(rv, 16'h0061);
		chk(ctrl_out, 16'hCC);
		// stopped controller ignores samples and holds its output
		wreg(A_CTRL, 16'h0);
		samp(16'h7F, 16'h0);
		chk(16'(out_valid), 16'h0);
		chk(ctrl_out, 16'hCC);
		chk(16'(running), 16'h0);
		// value start maps percentage between the limits, clipped at full scale
		for (int i = 0; i < 4; i++)
		begin
			r = rows[5];
			r.lo = 16'h10;
			r.hi = 16'hD8;
			cfg(3'h2, r, 16'h1, 16'(pcts[i]));
			chk(ctrl_out, 16'(16 + 200 * (pcts[i] > 100 ? 100 : pcts[i]) / 100));
		end
		// reset in mid-run clears output, run state and every set
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		#1 chk(ctrl_out, 16'h0);
		chk(16'(running), 16'h0000);
		rreg({1'b0, 3'h2, F_HILIM}, rv);
		chk(rv, RST_HILIM);
		chk(16'(outs_seen), 16'h000A);
		tally_and_finish();
	end
endmodule
